// file: shared/ctm_pkg.sv
package ctm_pkg;

  // Counter widths of the two instance flavours.
  localparam int CTM_WIDE_W   = 32;
  localparam int CTM_NARROW_W = 16;
  localparam int CTM_MATCH_N  = 4;
  localparam int CTM_CAP_W    = 32;

  // Reset values of the counting state and the match outputs.
  localparam logic [31:0] CTM_COUNT_RST = 32'h0000_0000;
  localparam logic [3:0]  CTM_OUT_RST   = 4'h0;

  // Bit positions of the per-match action field.
  localparam int CTM_ACT_IRQ   = 0;
  localparam int CTM_ACT_RESET = 1;
  localparam int CTM_ACT_STOP  = 2;

  // Count source selection.
  typedef enum logic [1:0] {
    CTM_SRC_TIMER,
    CTM_SRC_RISE,
    CTM_SRC_FALL,
    CTM_SRC_BOTH
  } ctm_src_t;

  // External match output action.
  typedef enum logic [1:0] {
    CTM_PIN_NONE,
    CTM_PIN_LOW,
    CTM_PIN_HIGH,
    CTM_PIN_TOGGLE
  } ctm_pin_t;

  // Capture configuration.
  typedef struct packed {
    logic onRise;
    logic onFall;
    logic irqEn;
    logic clrRise;
    logic clrFall;
  } ctm_cap_cfg_t;

  // Per-match configuration: action bits {stop, reset, irq} and pin action.
  typedef struct packed {
    logic [2:0] act;
    ctm_pin_t   pin;
  } ctm_match_cfg_t;

endpackage

// file: src/ctm_match_bank.sv
`timescale 1ns/1ps
// Holds the four match values; read data are registered, all four at once.
module ctm_match_bank #(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  // Write port
  input  wire logic                        wrEn,
  input  wire logic [1:0]                  wrIdx,
  input  wire logic [W-1:0]                wrData,
  // Registered read of all entries
  output logic      [ctm_pkg::CTM_MATCH_N-1:0][W-1:0] rdData
);
  import ctm_pkg::*;

  logic [CTM_MATCH_N-1:0][W-1:0] mem_r;

  // Storage with a synchronous write.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mem_r <= '0;
    end else if (wrEn) begin
      mem_r[wrIdx] <= wrData;
    end
  end

  // Registered copy, so compares see a stable value one cycle after a write.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdData <= '0;
    end else begin
      rdData <= mem_r;
    end
  end

endmodule

// file: src/ctm_timer.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Instances come as 32-bit or 16-bit via parameter W, each independent.
// - Prescaler has the counter's width and divides the count source.
// - Timer mode counts system clock cycles after prescaler division.
// - Counter mode counts chosen edges of an external input instead.
// - Four match values compare against the count; each may flag an interrupt.
// - Continuous match keeps counting, optional interrupt flag.
// - Stop match halts counting, optional interrupt flag.
// - Reset match returns count to zero and keeps counting.
// - Each match output can go low, high, toggle, or stay.
// - Capture copies the count on a selected input edge, optional interrupt.
// - Selected capture edge may clear both counter and prescaler.
module ctm_timer #(
  parameter int W = ctm_pkg::CTM_WIDE_W
) (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // Control
  input  wire logic                  runEn,
  input  wire logic                  swReset,
  input  wire ctm_pkg::ctm_src_t     srcSel,
  input  wire logic [W-1:0]          prescLimit,
  // Match configuration and value loading
  input  wire ctm_pkg::ctm_match_cfg_t [3:0] matchCfg,
  input  wire logic                  matchWr,
  input  wire logic [1:0]            matchIdx,
  input  wire logic [W-1:0]          matchData,
  // Capture
  input  wire ctm_pkg::ctm_cap_cfg_t capCfg,
  input  wire logic                  capIn,
  input  wire logic                  countIn,
  // Interrupt flag clear, one bit per flag: [3:0] matches, [4] capture
  input  wire logic [4:0]            flagClr,
  // Status
  output logic [W-1:0]               count,
  output logic [W-1:0]               prescCount,
  output logic [W-1:0]               capValue,
  output logic                       stopped,
  output logic [4:0]                 flags,
  output logic                       irq,
  output logic [3:0]                 matchOut
);
  import ctm_pkg::*;

  logic [W-1:0]          count_r, count_nxt;
  logic [W-1:0]          presc_r, presc_nxt;
  logic [W-1:0]          cap_r;
  logic                  stop_r;
  logic [4:0]            flags_r, flags_nxt;
  logic [3:0]            out_r, out_nxt;
  logic                  irq_r;
  logic                  capPrev_r, cntPrev_r;
  logic [3:0][W-1:0]     matchVal;

  ctm_match_bank #(.W(W)) u_bank (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wrEn    (matchWr),
    .wrIdx   (matchIdx),
    .wrData  (matchData),
    .rdData  (matchVal)
  );

  // Edge detection on the already-synchronous inputs.
  wire capRise = capIn & ~capPrev_r;
  wire capFall = ~capIn & capPrev_r;
  wire cntRise = countIn & ~cntPrev_r;
  wire cntFall = ~countIn & cntPrev_r;

  // Count source tick: clock cycles or selected external edges.
  wire srcTick = (srcSel == CTM_SRC_TIMER) ? 1'b1 :
                 (srcSel == CTM_SRC_RISE)  ? cntRise :
                 (srcSel == CTM_SRC_FALL)  ? cntFall :
                                             (cntRise | cntFall);

  wire running   = runEn & ~stop_r;
  wire prescWrap = running & srcTick & (presc_r >= prescLimit);
  wire countStep = prescWrap;

  // Capture and capture-clear events.
  wire capEvt = (capCfg.onRise & capRise) | (capCfg.onFall & capFall);
  wire capClr = (capCfg.clrRise & capRise) | (capCfg.clrFall & capFall);

  // A match fires when the counter reaches a match value on a count step.
  logic [3:0] matchHit;
  always_comb begin
    for (int i = 0; i < CTM_MATCH_N; i++) begin
      matchHit[i] = countStep && (count_r == matchVal[i]);
    end
  end

  // True when any hit match has the given action bit set; one decoder serves reset and stop.
  function automatic logic act_any(input logic [3:0]           hit,
                                   input ctm_match_cfg_t [3:0] cfg,
                                   input int                   bitPos);
    logic hitAny;
    hitAny = 1'b0;
    for (int k = 0; k < CTM_MATCH_N; k++) begin
      hitAny = hitAny | (hit[k] & cfg[k].act[bitPos]);
    end
    return hitAny;
  endfunction

  wire anyReset = act_any(matchHit, matchCfg, CTM_ACT_RESET);
  wire anyStop  = act_any(matchHit, matchCfg, CTM_ACT_STOP);

  // Prescaler next value; capture clear and software reset zero it too.
  always_comb begin
    presc_nxt = presc_r;
    if (swReset || capClr) begin
      presc_nxt = '0;
    end else if (running && srcTick) begin
      presc_nxt = prescWrap ? '0 : presc_r + 1'b1;
    end
  end

  // Counter next value. A reset match wins over the increment; stop just
  // freezes the count at the match value, which is what software expects.
  always_comb begin
    count_nxt = count_r;
    if (swReset || capClr) begin
      count_nxt = '0;
    end else if (countStep) begin
      if (anyReset) begin
        count_nxt = '0;
      end else if (!anyStop) begin
        count_nxt = count_r + 1'b1;
      end
    end
  end

  // Flags: a set arriving together with a clear wins.
  always_comb begin
    flags_nxt = flags_r & ~flagClr;
    for (int i = 0; i < CTM_MATCH_N; i++) begin
      if (matchHit[i] && matchCfg[i].act[CTM_ACT_IRQ]) begin
        flags_nxt[i] = 1'b1;
      end
    end
    if (capEvt && capCfg.irqEn) begin
      flags_nxt[4] = 1'b1;
    end
  end

  // Match output pins.
  always_comb begin
    out_nxt = out_r;
    for (int i = 0; i < CTM_MATCH_N; i++) begin
      if (matchHit[i]) begin
        unique case (matchCfg[i].pin)
          CTM_PIN_NONE:   out_nxt[i] = out_r[i];
          CTM_PIN_LOW:    out_nxt[i] = 1'b0;
          CTM_PIN_HIGH:   out_nxt[i] = 1'b1;
          CTM_PIN_TOGGLE: out_nxt[i] = ~out_r[i];
        endcase
      end
    end
  end

  // Counting state.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_r <= CTM_COUNT_RST[W-1:0];
      presc_r <= CTM_COUNT_RST[W-1:0];
    end else begin
      count_r <= count_nxt;
      presc_r <= presc_nxt;
    end
  end

  // Stop latch: set by a stop match, released by software reset.
  always_ff @(posedge ref_clk) begin
    if (rst || swReset) begin
      stop_r <= 1'b0;
    end else if (countStep && anyStop) begin
      stop_r <= 1'b1;
    end
  end

  // Capture register takes the count as it stood at the edge.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cap_r <= '0;
    end else if (capEvt) begin
      cap_r <= count_r;
    end
  end

  // Flags, pins, interrupt and edge history.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flags_r   <= '0;
      out_r     <= CTM_OUT_RST;
      irq_r     <= 1'b0;
      capPrev_r <= 1'b0;
      cntPrev_r <= 1'b0;
    end else begin
      flags_r   <= flags_nxt;
      out_r     <= out_nxt;
      irq_r     <= |flags_nxt;
      capPrev_r <= capIn;
      cntPrev_r <= countIn;
    end
  end

  // All outputs come straight from flip-flops.
  assign count      = count_r;
  assign prescCount = presc_r;
  assign capValue   = cap_r;
  assign stopped    = stop_r;
  assign flags      = flags_r;
  assign irq        = irq_r;
  assign matchOut   = out_r;

endmodule

// file: tb/ctm_timer_props.sv
`timescale 1ns/1ps
// Port checks on ref_clk; all idle while rst is high.
module ctm_timer_props #(
  parameter int W = 32
) (
  // Clock, reset
  input wire logic                  ref_clk,
  input wire logic                  rst,
  // Controls, pins
  input wire logic                  runEn,
  input wire logic                  swReset,
  input wire ctm_pkg::ctm_src_t     srcSel,
  input wire ctm_pkg::ctm_cap_cfg_t capCfg,
  input wire logic                  capIn,
  input wire logic                  countIn,
  input wire logic [4:0]            flagClr,
  // Status
  input wire logic [W-1:0]          count,
  input wire logic [W-1:0]          prescCount,
  input wire logic [W-1:0]          capValue,
  input wire logic                  stopped,
  input wire logic [4:0]            flags,
  input wire logic                  irq
);
  import ctm_pkg::*;
  // A clear may zero the count at any time, so hold checks leave it out.
  wire logic quiet = !swReset && !capCfg.clrRise && !capCfg.clrFall;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_irq_or: assert property (irq == |flags)
    else $error("irq not OR of flags");
  chk_flag_sticky: assert property (
    1 |=> (flags & $past(flags & ~flagClr)) == $past(flags & ~flagClr))
    else $error("flag lost");
  chk_run_hold: assert property (!runEn && quiet |=> $stable(count))
    else $error("count moved while off");
  chk_stop_hold: assert property (stopped && quiet |=> $stable(count))
    else $error("count moved while stopped");
  chk_count_mode: assert property (
    srcSel == CTM_SRC_RISE && !$rose(countIn) && quiet |=> $stable(count))
    else $error("count moved with no edge");
  chk_cap_value: assert property (
    capCfg.onRise && $rose(capIn) |=> capValue == $past(count))
    else $error("capture value wrong");
  chk_cap_flag: assert property (
    capCfg.onRise && capCfg.irqEn && $rose(capIn) |=> flags[4])
    else $error("capture flag missing");
  chk_cap_clear: assert property (
    capCfg.clrRise && $rose(capIn) |=> count == '0 && prescCount == '0)
    else $error("capture clear missed");
  cover property (stopped);
  cover property (irq);
  cover property (capCfg.clrRise && $rose(capIn));
endmodule

bind ctm_timer ctm_timer_props #(.W(W)) ctm_timer_props_inst (.ref_clk, .rst, .runEn,
  .swReset, .srcSel, .capCfg, .capIn, .countIn, .flagClr, .count, .prescCount,
  .capValue, .stopped, .flags, .irq);

// file: tb/ctm_pin_model.sv
`timescale 1ns/1ps
// External pins; registered so edges land just after a clock edge.
module ctm_pin_model (
  // Clock and wishes
  input wire logic ref_clk,
  input wire logic capReq,
  input wire logic cntReq,
  // Pins, idle low
  output logic     capIn = 1'b0,
  output logic     countIn = 1'b0
);
  // Pins follow the bench one cycle later.
  always @(posedge ref_clk) begin
    capIn <= capReq;
    countIn <= cntReq;
  end
endmodule

// file: tb/ctm_timer_tb.sv
`timescale 1ns/1ps
// Random traffic; every output is checked each cycle against a model.
module ctm_timer_tb;
  import ctm_pkg::*;
  logic                 ref_clk = 1'b0;
  logic                 rst, runEn, swReset, matchWr, capReq, cntReq;
  logic                 capIn, countIn, stopped, irq, ms, cP, kP, cr, cf, step, rs, st;
  ctm_src_t             srcSel;
  ctm_match_cfg_t [3:0] matchCfg;
  ctm_cap_cfg_t         capCfg;
  logic [1:0]           matchIdx;
  logic [3:0]           matchOut, mo, evs;
  logic [4:0]           flagClr, flags, mf, nf;
  logic [15:0]          prescLimit, matchData, count, prescCount, capValue;
  int                   seed, n_fail, comparisons, mc, mp, nc, np, mcap, mv[4], i, j, p, c;
  int                   mw[4];
  logic [31:0]          countW, prescW, capW;
  logic                 stoppedW, irqW;
  logic [3:0]           matchOutW;
  logic [4:0]           flagsW;
  always #5 ref_clk = ~ref_clk;
  ctm_pin_model ctm_pin_model_inst (.ref_clk, .capReq, .cntReq, .capIn, .countIn);
  ctm_timer #(.W(16)) ctm_timer_inst (.ref_clk, .rst, .runEn, .swReset, .srcSel,
    .prescLimit, .matchCfg, .matchWr, .matchIdx, .matchData, .capCfg, .capIn, .countIn,
    .flagClr, .count, .prescCount, .capValue, .stopped, .flags, .irq, .matchOut);
  // Wide twin on the same stimulus; small counts must read the same in both widths.
  ctm_timer #(.W(32)) ctm_timer_w32_inst (.ref_clk, .rst, .runEn, .swReset, .srcSel,
    .prescLimit ({16'h0000, prescLimit}), .matchCfg, .matchWr, .matchIdx,
    .matchData ({16'h0000, matchData}), .capCfg, .capIn, .countIn, .flagClr,
    .count (countW), .prescCount (prescW), .capValue (capW), .stopped (stoppedW),
    .flags (flagsW), .irq (irqW), .matchOut (matchOutW));
  task automatic cmpv(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Compare last cycle's prediction first, then advance; clear wins over match reset.
  always @(posedge ref_clk) begin
    if (rst) {mc, mp, mcap, mf, mo, ms, cP, kP} = '0;
    else begin
      cmpv(count, mc);
      cmpv(prescCount, mp);
      cmpv(capValue, mcap);
      cmpv({stopped, irq, matchOut, flags}, {ms, |mf, mo, mf});
      cmpv(countW, mc);
      cmpv(prescW, mp);
      cmpv(capW, mcap);
      cmpv({stoppedW, irqW, matchOutW, flagsW}, {ms, |mf, mo, mf});
      evs = {countIn ^ kP, !countIn & kP, countIn & !kP, 1'b1};
      nf = mf & ~flagClr;
      {nc, np, rs, st} = {mc, mp, 2'b0};
      if (runEn && !ms && evs[srcSel]) begin
        // A limit lowered below the running prescaler still wraps it at once.
        step = mp >= prescLimit;
        np = step ? 0 : mp + 1;
        for (j = 0; j < 4; j++) begin
          if (step && mc == mv[j]) begin
            nf[j] |= matchCfg[j].act[CTM_ACT_IRQ];
            rs |= matchCfg[j].act[CTM_ACT_RESET];
            st |= matchCfg[j].act[CTM_ACT_STOP];
            if (matchCfg[j].pin == CTM_PIN_TOGGLE) mo[j] = !mo[j];
            else if (matchCfg[j].pin != CTM_PIN_NONE) mo[j] = matchCfg[j].pin == CTM_PIN_HIGH;
          end
        end
        if (step) nc = rs ? 0 : st ? mc : mc + 1;
        // A stop hit latches even when a reset hit zeroes the count.
        ms = step && st;
      end
      cr = capIn & !cP;
      cf = !capIn & cP;
      if (capCfg.onRise && cr || capCfg.onFall && cf) begin
        mcap = mc;
        nf[4] |= capCfg.irqEn;
      end
      if (capCfg.clrRise && cr || capCfg.clrFall && cf) {nc, np} = '0;
      if (swReset) {nc, np, ms} = '0;
      // A written match value reaches the compare two edges later, as the bank registers it twice.
      mv = mw;
      if (matchWr) mw[matchIdx] = int'(matchData);
      {mc, mp, mf, kP, cP} = {nc, np, nf, countIn, capIn};
    end
  end
  initial begin
    seed = 48356;
    {rst, runEn, swReset, matchWr, capReq, cntReq, matchIdx, flagClr} = 13'h1000;
    {prescLimit, matchData, matchCfg, capCfg, n_fail, comparisons} = '0;
    srcSel = CTM_SRC_TIMER;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    for (i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      {matchWr, matchIdx, matchData} <= {1'b1, 2'(i), 16'(i + 3)};
    end
    @(posedge ref_clk);
    matchWr <= 1'b0;
    // Phases 0..3 walk each count source; phase 4 must halt at 6.
    // Match 1 toggles its pin on even phases and drives it low on odd ones.
    for (p = 0; p < 5; p++) begin
      matchCfg <= {5'(p == 4 ? 5'h16 : 5'h04), 5'(p % 4 ? 5'h0F : 5'h07),
                   5'(p % 2 ? 5'h01 : 5'h03), 5'h06};
      srcSel <= ctm_src_t'(p % 4);
      prescLimit <= 16'(p % 3);
      swReset <= 1'b1;
      @(posedge ref_clk);
      swReset <= 1'b0;
      for (c = 0; c < 150; c++) begin
        runEn <= 2'($random(seed)) != 2'h0;
        {cntReq, capReq} <= 2'($random(seed));
        capCfg <= p < 4 ? 5'($random(seed)) : 5'h00;
        flagClr <= 5'($random(seed) & $random(seed));
        @(posedge ref_clk);
      end
    end
    report_and_stop;
  end
endmodule
